/* acr_cfg.svh */
// Register offsets, field positions, reset values and counts of the recovery timestamper
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACR_OFF_TIMING 6'h10
`define ACR_OFF_TSCTL 6'h12
`define ACR_OFF_FBDIV 6'h14
`define ACR_OFF_INSEN 6'h16
`define ACR_OFF_INSPOS 6'h17
`define ACR_OFF_CLSOFF 6'h2d
`define ACR_OFF_CLSWR 6'h2e
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACR_TC_TOP 0
`define ACR_TC_THROTTLE 1
`define ACR_SC_ING_SRC 0
`define ACR_SC_FB_SRC 1
`define ACR_SC_DIV2_HI 15
`define ACR_SC_DIV2_LO 8
`define ACR_IE_TOP 0
`define ACR_IP_NANOSECOND_INSERT_ENABLE 15
`define ACR_IP_OFF_HI 10
`define ACR_IP_OFF_LO 0
`define ACR_WR_STROBE 0
`define ACR_WR_SEL_HI 7
`define ACR_WR_SEL_LO 4
// ----------------------------------------
// Values and counts
// ----------------------------------------
`define ACR_RST_REG 16'h0000
`define ACR_SEL_SEQ_OFF 4'hf
`define ACR_INS_LEN 11'h00a
`define ACR_INS_FIX_HI 11'h008
`define ACR_INS_FIX_LO 11'h009
`endif

/* acr_pkg.sv */
// Types shared by the recovery timestamper files
package acr_pkg;
	// Register access port
	typedef struct packed {
		logic wr;
		logic [5:0] addr;
		logic [15:0] wdata;
	} acr_reg_req_t;
	// One byte of the ingress packet stream
	typedef struct packed {
		logic valid;
		logic sop;
		logic eop;
		logic [7:0] data;
	} acr_beat_t;
	// Ingress queue entry: timestamp and sequence number
	typedef struct packed {
		logic [31:0] ts_ns;
		logic [15:0] seq;
	} acr_ing_entry_t;
	// Insertion pointer state
	typedef enum logic [2:0] {
		ACR_INS_IDLE = 3'b001,
		ACR_INS_RUN = 3'b010,
		ACR_INS_DONE = 3'b100
	} acr_ins_state_t;
endpackage

/* acr_fb_divider.sv */
// Two cascaded feedback dividers feeding the feedback timestamper
module acr_fb_divider (
	input wire logic ref_clk, // Datapath clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic enable, // Recovery mode on
	input wire logic edge_in, // Feedback edge pulse
	input wire logic [15:0] div_first, // First divide ratio, 0 or 1 bypasses
	input wire logic [15:0] div_second, // Second divide ratio, 0 or 1 bypasses
	output logic edge_out // Divided edge pulse
);
	import acr_pkg::*;

	logic [2:0] stage_pulse;
	logic [15:0] ratio [2];

	assign stage_pulse[0] = edge_in;
	assign ratio[0] = div_first;
	assign ratio[1] = div_second;

	// ----------------------------------------
	// Divider stages
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_stage
			logic [15:0] cnt_reg;
			logic bypass;
			assign bypass = (ratio[g] <= 16'h0001);
			// Count edges, emit one every ratio edges
			always_ff @(posedge ref_clk) begin
				if (rst || !enable || bypass) begin
					cnt_reg <= 16'h0000;
				end else if (stage_pulse[g]) begin
					cnt_reg <= (cnt_reg == ratio[g] - 16'h0001) ? 16'h0000 : cnt_reg + 16'h0001;
				end
			end
			assign stage_pulse[g + 1] = stage_pulse[g] &&
				(bypass || cnt_reg == ratio[g] - 16'h0001);
		end
	endgenerate

	// Registered output pulse
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			edge_out <= 1'b0;
		end else begin
			edge_out <= enable && stage_pulse[2];
		end
	end

	div_bypass_a: assert property (@(posedge ref_clk) disable iff (rst)
		enable && div_first <= 16'h0001 && div_second <= 16'h0001 && edge_in |=> edge_out)
		else $error("bypassed divider lost an edge");
endmodule

/* acr_timestamper.sv */
// Packet and feedback timestamping for adaptive clock recovery
`include "acr_cfg.svh"
module acr_timestamper (
	input wire logic ref_clk, // Datapath clock, 200 MHz
	input wire logic rst, // Synchronous reset, active high
	input acr_pkg::acr_reg_req_t reg_req, // Register write and address
	output logic [15:0] reg_rdata, // Register read data
	input wire logic [31:0] time_ns, // Time engine nanoseconds
	input wire logic fb_edge, // Feedback generator edge pulse
	input wire logic pkt_qual, // Classifier marks packet qualified
	input acr_pkg::acr_beat_t rx_in, // Ingress byte stream in
	output acr_pkg::acr_beat_t rx_out, // Ingress byte stream out
	output logic ing_push, // Ingress queue write strobe
	output acr_pkg::acr_ing_entry_t ing_entry, // Ingress queue entry
	output logic fb_push, // Feedback queue write strobe
	output logic [31:0] fb_ts, // Feedback queue entry
	output logic [10:0] seq_offset // Sequence field offset in use
);
	import acr_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] timing_reg, tsctl_reg, fbdiv_reg, insen_reg, inspos_reg, clsoff_reg, clswr_reg;
	logic [15:0] seqoff_reg;
	logic top_mode, throttle, ins_on;
	logic [10:0] ins_off;

	assign top_mode = timing_reg[`ACR_TC_TOP];
	assign throttle = timing_reg[`ACR_TC_THROTTLE];
	assign ins_off = inspos_reg[`ACR_IP_OFF_HI:`ACR_IP_OFF_LO];
	assign ins_on = top_mode && insen_reg[`ACR_IE_TOP] && inspos_reg[`ACR_IP_NANOSECOND_INSERT_ENABLE];
	assign seq_offset = seqoff_reg[10:0];

	// Software writes; write strobe self-clears
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			timing_reg <= `ACR_RST_REG;
			tsctl_reg <= `ACR_RST_REG;
			fbdiv_reg <= `ACR_RST_REG;
			insen_reg <= `ACR_RST_REG;
			inspos_reg <= `ACR_RST_REG;
			clsoff_reg <= `ACR_RST_REG;
			clswr_reg <= `ACR_RST_REG;
		end else begin
			clswr_reg[`ACR_WR_STROBE] <= 1'b0;
			if (reg_req.wr) begin
				unique case (reg_req.addr)
					`ACR_OFF_TIMING: timing_reg <= reg_req.wdata;
					`ACR_OFF_TSCTL: tsctl_reg <= reg_req.wdata;
					`ACR_OFF_FBDIV: fbdiv_reg <= reg_req.wdata;
					`ACR_OFF_INSEN: insen_reg <= reg_req.wdata;
					`ACR_OFF_INSPOS: inspos_reg <= reg_req.wdata;
					`ACR_OFF_CLSOFF: clsoff_reg <= reg_req.wdata;
					`ACR_OFF_CLSWR: clswr_reg <= reg_req.wdata;
					default: ;
				endcase
			end
		end
	end

	// Sequence offset load from classifier offset data
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seqoff_reg <= `ACR_RST_REG;
		end else if (clswr_reg[`ACR_WR_STROBE] &&
			clswr_reg[`ACR_WR_SEL_HI:`ACR_WR_SEL_LO] == `ACR_SEL_SEQ_OFF) begin
			seqoff_reg <= clsoff_reg;
		end
	end

	// Read back, unmapped offsets read zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else begin
			unique case (reg_req.addr)
				`ACR_OFF_TIMING: reg_rdata <= timing_reg;
				`ACR_OFF_TSCTL: reg_rdata <= tsctl_reg;
				`ACR_OFF_FBDIV: reg_rdata <= fbdiv_reg;
				`ACR_OFF_INSEN: reg_rdata <= insen_reg;
				`ACR_OFF_INSPOS: reg_rdata <= inspos_reg;
				`ACR_OFF_CLSOFF: reg_rdata <= clsoff_reg;
				`ACR_OFF_CLSWR: reg_rdata <= clswr_reg;
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------
	// Feedback path
	// ----------------------------------------
	logic fb_div_edge;
	logic [31:0] fb_latest_reg;

	acr_fb_divider u_div (
		.ref_clk(ref_clk),
		.rst(rst),
		.enable(top_mode),
		.edge_in(fb_edge),
		.div_first(fbdiv_reg),
		.div_second({8'h00, tsctl_reg[`ACR_SC_DIV2_HI:`ACR_SC_DIV2_LO]}),
		.edge_out(fb_div_edge)
	);

	// Feedback capture, holding register and queue strobe
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fb_latest_reg <= 32'h00000000;
			fb_ts <= 32'h00000000;
			fb_push <= 1'b0;
		end else begin
			fb_push <= fb_div_edge && top_mode && !tsctl_reg[`ACR_SC_FB_SRC];
			if (fb_div_edge) begin
				fb_latest_reg <= time_ns;
				fb_ts <= time_ns;
			end
		end
	end

	// ----------------------------------------
	// Ingress capture
	// ----------------------------------------
	logic [10:0] idx_reg, cur_idx;
	logic [31:0] pkt_ts_reg, pkt_fb_reg, cur_ts, cur_fb;
	logic [15:0] seq_reg;
	logic qual_reg, qual_now, allow_reg, ing_ok;

	assign qual_now = qual_reg || pkt_qual;
	assign ing_ok = !throttle || allow_reg;
	assign cur_idx = rx_in.sop ? 11'h000 : idx_reg;
	// Sop byte sees its own timestamps before the registers load
	assign cur_ts = rx_in.sop ? time_ns : pkt_ts_reg;
	assign cur_fb = rx_in.sop ? fb_latest_reg : pkt_fb_reg;

	// Byte index, packet timestamp, qualification
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			idx_reg <= 11'h000;
			pkt_ts_reg <= 32'h00000000;
			pkt_fb_reg <= 32'h00000000;
			qual_reg <= 1'b0;
		end else if (rx_in.valid) begin
			idx_reg <= rx_in.sop ? 11'h001 : idx_reg + 11'h001;
			qual_reg <= !rx_in.eop && top_mode && (rx_in.sop ? pkt_qual : qual_now);
			if (rx_in.sop) begin
				pkt_ts_reg <= time_ns;
				pkt_fb_reg <= fb_latest_reg;
			end
		end
	end

	// Sequence number capture, high byte first
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seq_reg <= 16'h0000;
		end else if (rx_in.valid) begin
			if (cur_idx == seq_offset) begin
				seq_reg[15:8] <= rx_in.data;
			end else if (cur_idx == seq_offset + 11'h001) begin
				seq_reg[7:0] <= rx_in.data;
			end
		end
	end

	// Queue push at packet end, throttled by feedback entries
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ing_push <= 1'b0;
			ing_entry <= '0;
			allow_reg <= 1'b0;
		end else begin
			ing_push <= 1'b0;
			if (rx_in.valid && rx_in.eop && qual_now && top_mode && ing_ok &&
				!tsctl_reg[`ACR_SC_ING_SRC]) begin
				ing_push <= 1'b1;
				ing_entry.ts_ns <= pkt_ts_reg;
				ing_entry.seq <= (cur_idx == seq_offset + 11'h001) ? {seq_reg[15:8], rx_in.data}
					: seq_reg;
				allow_reg <= 1'b0;
			end
			if (fb_push) begin
				allow_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// On-the-fly insertion
	// ----------------------------------------
	function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction

	acr_ins_state_t ins_state;
	logic [10:0] rel;
	logic [15:0] old_sum_reg, new_sum, fix;
	logic [7:0] old_hi_reg, ins_byte;
	logic [79:0] ins_block;

	assign rel = cur_idx - ins_off;
	assign new_sum = oc_add(oc_add(cur_ts[31:16], cur_ts[15:0]),
		oc_add(cur_fb[31:16], cur_fb[15:0]));
	assign fix = oc_add(old_sum_reg, ~new_sum);
	assign ins_block = {cur_ts, cur_fb, fix};
	assign ins_byte = ins_block[8'(79 - 8 * rel) -: 8];

	// Insertion window tracking per packet
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ins_state <= ACR_INS_IDLE;
		end else if (rx_in.valid) begin
			unique case (ins_state)
				ACR_INS_IDLE: if (rx_in.sop && !rx_in.eop) ins_state <= ACR_INS_RUN;
				ACR_INS_RUN: if (rx_in.eop) ins_state <= ACR_INS_IDLE;
					else if (rel == `ACR_INS_FIX_LO && cur_idx >= ins_off) ins_state <= ACR_INS_DONE;
				ACR_INS_DONE: if (rx_in.eop) ins_state <= ACR_INS_IDLE;
				default: ins_state <= ACR_INS_IDLE;
			endcase
		end
	end

	logic in_win;
	assign in_win = ins_on && qual_now && cur_idx >= ins_off && rel < `ACR_INS_LEN &&
		(rx_in.sop || ins_state == ACR_INS_RUN);

	// Sum of the four words overwritten by the timestamps, not the fix word, for the checksum fix
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			old_sum_reg <= 16'h0000;
			old_hi_reg <= 8'h00;
		end else if (rx_in.valid && in_win && rel < `ACR_INS_FIX_HI) begin
			if (rel[0]) begin
				old_sum_reg <= (rel == 11'h001) ? {old_hi_reg, rx_in.data}
					: oc_add(old_sum_reg, {old_hi_reg, rx_in.data});
			end else begin
				old_hi_reg <= rx_in.data;
			end
		end
	end

	// Stream out, registered, with inserted bytes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_out <= '0;
		end else begin
			rx_out <= rx_in;
			if (rx_in.valid && in_win) begin
				rx_out.data <= ins_byte;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence fb_capture_s;
		fb_div_edge && top_mode && !tsctl_reg[`ACR_SC_FB_SRC];
	endsequence
	sequence fb_pushed_s;
		fb_push && fb_ts == fb_latest_reg;
	endsequence

	top_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		!top_mode |=> !ing_push && !fb_push)
		else $error("queue push while recovery mode off");
	fb_queue_a: assert property (@(posedge ref_clk) disable iff (rst)
		fb_capture_s |=> fb_pushed_s)
		else $error("feedback timestamp not queued");
	fb_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		fb_div_edge |=> fb_latest_reg == $past(time_ns))
		else $error("feedback holding register stale");
	seq_load_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_req.wr && reg_req.addr == `ACR_OFF_CLSWR && reg_req.wdata[`ACR_WR_STROBE] &&
		reg_req.wdata[`ACR_WR_SEL_HI:`ACR_WR_SEL_LO] == `ACR_SEL_SEQ_OFF
		|=> ##1 seqoff_reg == $past(clsoff_reg))
		else $error("sequence offset not loaded");
	ing_src_a: assert property (@(posedge ref_clk) disable iff (rst)
		ing_push |-> !$past(tsctl_reg[`ACR_SC_ING_SRC]))
		else $error("ingress push with source select set");
	throttle_one_a: assert property (@(posedge ref_clk) disable iff (rst)
		throttle && ing_push && !fb_push && !$past(fb_push) |=> !ing_push until_with fb_push)
		else $error("second ingress entry without feedback entry");
	ins_first_a: assert property (@(posedge ref_clk) disable iff (rst)
		rx_in.valid && in_win && rel == 11'h000 |=> rx_out.data == pkt_ts_reg[31:24])
		else $error("insert does not start with packet ns high byte");
	ins_fb_a: assert property (@(posedge ref_clk) disable iff (rst)
		rx_in.valid && in_win && rel == 11'h004 |=> rx_out.data == $past(pkt_fb_reg[31:24]))
		else $error("feedback ns not at fifth inserted byte");
	ins_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		rx_in.valid && !ins_on |=> rx_out.data == $past(rx_in.data))
		else $error("packet modified with insertion disabled");
endmodule

/* acr_pkt_src.sv */
// Model of the emulation packet network feeding the ingress byte stream
module acr_pkt_src (
	input wire logic ref_clk, // Datapath clock
	output acr_pkg::acr_beat_t beat, // Ingress byte stream
	output logic qual // Classifier qualification
);
	timeunit 1ns;
	timeprecision 100ps;
	import acr_pkg::*;
	// Idle stream at time zero
	initial begin
		beat = '0;
		qual = 1'b0;
	end
	// Send one packet byte by byte, qualification held through the frame
	task automatic send(input logic [7:0] pkt[$], input logic q);
		for (int i = 0; i < pkt.size(); i++) begin
			@(negedge ref_clk);
			beat <= {1'b1, i == 0, i == pkt.size() - 1, pkt[i]};
			qual <= q;
		end
		@(negedge ref_clk);
		// Released data shows the inverse of the last byte, never a stale copy
		beat <= {3'b000, ~pkt[pkt.size() - 1]};
		qual <= 1'b0;
	endtask
endmodule

/* testbench.sv */
// Self-checking bench of the recovery timestamper
`include "acr_cfg.svh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import acr_pkg::*;
	logic ref_clk, rst, fb_edge, pkt_qual, ing_push, fb_push;
	acr_reg_req_t reg_req;
	logic [15:0] reg_rdata, rv;
	logic [31:0] time_ns, fb_ts, fb_last;
	acr_beat_t rx_in, rx_out;
	acr_ing_entry_t ing_entry;
	logic [10:0] seq_offset;
	logic [47:0] ing_seen[$];
	logic [31:0] fb_seen[$], fb_exp[$], sop_ts[$];
	logic [7:0] out_bytes[$];
	int num_errors = 0, samples_checked = 0, seed = 70650;
	int fb_cnt = 0, fb_div = 1, seq_at = 4, ioff = 20;
	logic mode_on = 1'b0, fb_q_on = 1'b0, fb_pend = 1'b0;
	acr_timestamper dut (.ref_clk, .rst, .reg_req, .reg_rdata, .time_ns, .fb_edge, .pkt_qual,
		.rx_in, .rx_out, .ing_push, .ing_entry, .fb_push, .fb_ts, .seq_offset);
	acr_pkt_src src (.ref_clk(ref_clk), .beat(rx_in), .qual(pkt_qual));
	// ----------------------------------------
	// Clock, time engine and watchdog
	// ----------------------------------------
	initial begin
		// Time engine set before the first clock event can advance it
		time_ns = 32'($random(seed));
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) time_ns <= time_ns + 32'h0000_0005;
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		wrap_up();
	end
	// Monitor: expected feedback captures and what the design hands out
	always @(posedge ref_clk) begin
		if (fb_pend) begin
			fb_last = time_ns;
			if (fb_q_on) fb_exp.push_back(time_ns);
		end
		fb_pend = 1'b0;
		if (fb_edge && mode_on) begin
			fb_cnt++;
			if (fb_cnt >= fb_div) begin
				fb_cnt = 0;
				fb_pend = 1'b1;
			end
		end
		if (fb_push) fb_seen.push_back(fb_ts);
		if (ing_push) ing_seen.push_back(ing_entry);
		if (rx_in.valid && rx_in.sop) sop_ts.push_back(time_ns);
		if (rx_out.valid) out_bytes.push_back(rx_out.data);
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		reg_req <= '{1'b1, a, d};
		@(negedge ref_clk);
		reg_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		@(negedge ref_clk);
		reg_req <= '{1'b0, a, 16'h0000};
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	// Feedback generator pulses at whole-cycle spacing
	task automatic fb_pulses(input int n);
		repeat (n) begin
			@(negedge ref_clk);
			fb_edge <= 1'b1;
			@(negedge ref_clk);
			fb_edge <= 1'b0;
			repeat (($random(seed) & 3) + 1) @(negedge ref_clk);
		end
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic fb_cmp;
		check(fb_seen.size(), fb_exp.size());
		for (int k = 0; k < fb_seen.size() && k < fb_exp.size(); k++) begin
			check(fb_seen[k], fb_exp[k]);
		end
		fb_seen = {};
		fb_exp = {};
	endtask
	// One's complement 16-bit add with end-around carry
	function automatic logic [15:0] oc16(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction
	// Send one packet and compare the stream and the queue entry
	task automatic pkt_run(input logic q, input logic push_exp, input logic ins);
		logic [7:0] pkt[$];
		logic [63:0] w;
		logic [15:0] osum, nsum, fx;
		int k;
		pkt = {};
		for (k = 0; k < 40; k++) pkt.push_back(8'($random(seed)));
		out_bytes = {};
		sop_ts = {};
		ing_seen = {};
		src.send(pkt, q);
		repeat (4) @(negedge ref_clk);
		w = {sop_ts[0], fb_last}; // Phase error pair for the software loop
		// Checksum fix: old words plus the complement of the new ones
		osum = 16'h0000;
		nsum = 16'h0000;
		for (k = 0; k < 4; k++) begin
			osum = oc16(osum, {pkt[ioff + 2 * k], pkt[ioff + 2 * k + 1]});
			nsum = oc16(nsum, w[16 * (3 - k) +: 16]);
		end
		fx = oc16(osum, ~nsum);
		check(out_bytes.size(), 40);
		for (k = 0; k < 40 && k < out_bytes.size(); k++) begin
			if (ins && k >= ioff && k < ioff + 8) begin
				check(out_bytes[k], w[8 * (ioff + 7 - k) +: 8]);
			end else if (ins && k >= ioff + 8 && k < ioff + 10) begin
				check(out_bytes[k], fx[8 * (ioff + 9 - k) +: 8]);
			end else begin
				check(out_bytes[k], pkt[k]);
			end
		end
		check(ing_seen.size(), push_exp);
		if (push_exp && ing_seen.size() > 0) begin
			check(ing_seen[0], {sop_ts[0], pkt[seq_at], pkt[seq_at + 1]});
		end
	endtask
	task automatic wrap_up;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		fb_edge = 1'b0;
		reg_req = '0;
		repeat (12) @(negedge ref_clk);
		rst <= 1'b0;
		// Reset values and the unmapped read
		for (int i = 0; i < 8; i++) begin
			rd(6'h10 + 6'(i), rv);
			check(rv, 16'h0000);
		end
		rd(`ACR_OFF_CLSOFF, rv);
		check(rv, 16'h0000);
		rd(`ACR_OFF_CLSWR, rv);
		check(rv, 16'h0000);
		wr(6'h3f, 16'($random(seed)));
		rd(6'h3f, rv);
		check(rv, 16'h0000);
		// Divider and offset data read back, then divider back to bypass
		w_rb(`ACR_OFF_FBDIV);
		w_rb(`ACR_OFF_CLSOFF);
		wr(`ACR_OFF_FBDIV, 16'h0000);
		// Sequence offset loads only with target 1111
		wr(`ACR_OFF_CLSOFF, 16'(seq_at));
		wr(`ACR_OFF_CLSWR, 16'h0051);
		@(negedge ref_clk);
		check(seq_offset, 11'h000);
		wr(`ACR_OFF_CLSWR, 16'h00f1);
		@(negedge ref_clk);
		check(seq_offset, 11'(seq_at));
		rd(`ACR_OFF_CLSWR, rv);
		check(rv[0], 1'b0);
		// Mode off: nothing is captured
		fb_pulses(2);
		pkt_run(1'b1, 1'b0, 1'b0);
		check(fb_seen.size(), 0);
		// Mode on: queues fed, unqualified packets skipped
		wr(`ACR_OFF_TIMING, 16'h0001);
		mode_on = 1'b1;
		fb_q_on = 1'b1;
		fb_pulses(3);
		fb_cmp();
		pkt_run(1'b1, 1'b1, 1'b0);
		pkt_run(1'b0, 1'b0, 1'b0);
		// Both queues deselected, insertion uses the newest feedback value
		wr(`ACR_OFF_TSCTL, 16'h0003);
		fb_q_on = 1'b0;
		fb_pulses(2);
		fb_cmp();
		wr(`ACR_OFF_INSEN, 16'h0001);
		wr(`ACR_OFF_INSPOS, 16'h8000 | 16'(ioff));
		pkt_run(1'b1, 1'b0, 1'b1);
		// Nanosecond enable cleared alone leaves the packet untouched
		wr(`ACR_OFF_INSPOS, 16'(ioff));
		pkt_run(1'b1, 1'b0, 1'b0);
		// Throttle: one ingress entry per feedback entry
		wr(`ACR_OFF_TSCTL, 16'h0000);
		wr(`ACR_OFF_INSEN, 16'h0000);
		wr(`ACR_OFF_TIMING, 16'h0003);
		fb_q_on = 1'b1;
		fb_pulses(1);
		pkt_run(1'b1, 1'b1, 1'b0);
		pkt_run(1'b1, 1'b0, 1'b0);
		fb_pulses(1);
		pkt_run(1'b1, 1'b1, 1'b0);
		fb_cmp();
		// Cascaded dividers 3 and 2 give one capture per six edges
		wr(`ACR_OFF_TIMING, 16'h0001);
		wr(`ACR_OFF_FBDIV, 16'h0003);
		wr(`ACR_OFF_TSCTL, 16'h0200);
		fb_div = 6;
		fb_cnt = 0;
		fb_pulses(12);
		fb_cmp();
		wrap_up();
	end
	// Write a random word and read it back
	task automatic w_rb(input logic [5:0] a);
		logic [15:0] d;
		logic [15:0] r;
		d = 16'($random(seed));
		wr(a, d);
		rd(a, r);
		check(r, d);
	endtask
endmodule
